// ===== logic/add_decode_pkg.sv
// Purpose: Constants and types for the add family decoder and flag unit.
// Assumes: One CPU clock; opcode bytes arrive from the fetch unit.
// Notes: Flag field order is C,Z,S,V,D,H from bit 5 down to bit 0.
// Summary of operation
// - Opcodes 12..17 add dst, src, carry.
// - Opcodes 18, 19 extended add with carry.
// - Opcodes 02..09 plain add, carry ignored.
// - Update C Z S V H; force D to 0.
// - Fetch 2 working, 3 register, 4 extended.
// - Execute 3 cycles, 4 with indirect operand.
// - Star flags recomputed, dash kept, zero cleared.
package add_decode_pkg;
    typedef enum logic [6:0] {
        working_mode           = 7'h01,
        indirect_working_mode  = 7'h02,
        register_mode          = 7'h04,
        indirect_register_mode = 7'h08,
        immediate_mode         = 7'h10,
        extended_register_mode = 7'h20,
        no_mode                = 7'h40
    } addr_mode_e;

    typedef struct packed {
        logic       valid;
        logic       with_carry;
        logic       extended;
        addr_mode_e dst_mode;
        addr_mode_e src_mode;
        logic [2:0] fetch_cycles;
        logic [2:0] exec_cycles;
    } decode_s;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } flags_s;

    localparam logic [3:0] ADD_BASE_HI   = 4'h0;
    localparam logic [3:0] ADC_BASE_HI   = 4'h1;
    localparam logic [3:0] LO_RR_WORK    = 4'h2;
    localparam logic [3:0] LO_R_IWORK    = 4'h3;
    localparam logic [3:0] LO_REG_REG    = 4'h4;
    localparam logic [3:0] LO_REG_IREG   = 4'h5;
    localparam logic [3:0] LO_REG_IMM    = 4'h6;
    localparam logic [3:0] LO_IREG_IMM   = 4'h7;
    localparam logic [3:0] LO_EXT_EXT    = 4'h8;
    localparam logic [3:0] LO_EXT_IMM    = 4'h9;

    localparam logic [2:0] FETCH_WORKING  = 3'h2;
    localparam logic [2:0] FETCH_REGISTER = 3'h3;
    localparam logic [2:0] FETCH_EXTENDED = 3'h4;
    localparam logic [2:0] EXEC_DIRECT    = 3'h3;
    localparam logic [2:0] EXEC_INDIRECT  = 3'h4;

    localparam int          HALF_BIT      = 4;
    localparam logic [7:0]  RESULT_RESET  = 8'h00;
    localparam logic [5:0]  FLAGS_RESET   = 6'h00;
endpackage

// ===== logic/add_flag_unit.sv
// Purpose: Eight-bit adder with carry, zero, sign, overflow, half-carry.
// Assumes: Purely combinational; the caller registers the outputs.
// Notes: Carry in is gated by the caller for plain add.
`timescale 1ns/1ps
module add_flag_unit
    import add_decode_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic      [7:0] sum,
    output flags_s          flags
);
    wire logic [8:0] full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    wire logic [4:0] low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

    assign sum     = full[7:0];
    assign flags.c = full[8];
    assign flags.z = (full[7:0] == 8'h00);
    assign flags.s = full[7];
    assign flags.v = (a[7] == b[7]) && (full[7] != a[7]);
    assign flags.d = 1'b0;
    assign flags.h = low[HALF_BIT];
endmodule

// ===== logic/cpu_add_carry_decode.sv
// Purpose: Decode the add family and update arithmetic flags on execute.
// Assumes: Operands are already fetched; one execute request per pulse.
// Notes: Codes outside the family decode as invalid and leave flags alone.
`timescale 1ns/1ps
module cpu_add_carry_decode
    import add_decode_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] opcode,
    input  wire logic       execute,
    input  wire logic [7:0] dst_value,
    input  wire logic [7:0] src_value,
    input  wire flags_s     flags_in,
    output decode_s         decode,
    output logic      [7:0] result,
    output flags_s          flags_out,
    output logic            write_dst,
    output logic            done
);
    // The high nibble picks plain or carry add, the low nibble the operands.
    wire logic [3:0]  hi;
    wire logic [3:0]  lo;
    wire logic [15:0] lo_hit;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    for (genvar code_i = 0; code_i < 16; code_i++) begin : g_lo_hit
        assign lo_hit[code_i] = (lo == 4'(code_i));
    end

    wire logic enc_rr_work;
    wire logic enc_r_iwork;
    wire logic enc_reg_reg;
    wire logic enc_reg_ireg;
    wire logic enc_reg_imm;
    wire logic enc_ireg_imm;
    wire logic enc_ext_ext;
    wire logic enc_ext_imm;

    assign enc_rr_work  = lo_hit[LO_RR_WORK];
    assign enc_r_iwork  = lo_hit[LO_R_IWORK];
    assign enc_reg_reg  = lo_hit[LO_REG_REG];
    assign enc_reg_ireg = lo_hit[LO_REG_IREG];
    assign enc_reg_imm  = lo_hit[LO_REG_IMM];
    assign enc_ireg_imm = lo_hit[LO_IREG_IMM];
    assign enc_ext_ext  = lo_hit[LO_EXT_EXT];
    assign enc_ext_imm  = lo_hit[LO_EXT_IMM];

    wire logic is_adc;
    wire logic is_add;
    wire logic lo_basic;
    wire logic lo_ext;

    assign is_adc   = (hi == ADC_BASE_HI);
    assign is_add   = (hi == ADD_BASE_HI);
    assign lo_basic = enc_rr_work | enc_r_iwork | enc_reg_reg |
                      enc_reg_ireg | enc_reg_imm | enc_ireg_imm;
    assign lo_ext   = enc_ext_ext | enc_ext_imm;

    wire logic op_adc_basic;
    wire logic op_adc_ext;
    wire logic op_add_basic;
    wire logic op_add_ext;
    wire logic fam_valid;
    wire logic with_carry;

    assign op_adc_basic = is_adc & lo_basic;
    assign op_adc_ext   = is_adc & lo_ext;
    assign op_add_basic = is_add & lo_basic;
    assign op_add_ext   = is_add & lo_ext;
    assign fam_valid    = op_adc_basic | op_adc_ext |
                          op_add_basic | op_add_ext;
    assign with_carry   = op_adc_basic | op_adc_ext;

    // Destination operand class, one line per addressing mode.
    wire logic dst_working;
    wire logic dst_register;
    wire logic dst_indirect_reg;
    wire logic dst_extended;

    assign dst_working      = enc_rr_work | enc_r_iwork;
    assign dst_register     = enc_reg_reg | enc_reg_ireg | enc_reg_imm;
    assign dst_indirect_reg = enc_ireg_imm;
    assign dst_extended     = lo_ext;

    wire logic src_working;
    wire logic src_indirect_work;
    wire logic src_register;
    wire logic src_indirect_reg;
    wire logic src_immediate;
    wire logic src_extended;

    assign src_working       = enc_rr_work;
    assign src_indirect_work = enc_r_iwork;
    assign src_register      = enc_reg_reg;
    assign src_indirect_reg  = enc_reg_ireg;
    assign src_immediate     = enc_reg_imm | enc_ireg_imm | enc_ext_imm;
    assign src_extended      = enc_ext_ext;

    wire addr_mode_e dst_m;
    wire addr_mode_e src_m;

    assign dst_m = !fam_valid       ? no_mode :
                   dst_extended     ? extended_register_mode :
                   dst_indirect_reg ? indirect_register_mode :
                   dst_working      ? working_mode :
                   dst_register     ? register_mode : no_mode;
    assign src_m = !fam_valid        ? no_mode :
                   src_working       ? working_mode :
                   src_indirect_work ? indirect_working_mode :
                   src_register      ? register_mode :
                   src_indirect_reg  ? indirect_register_mode :
                   src_extended      ? extended_register_mode :
                   src_immediate     ? immediate_mode : no_mode;

    // Fetch length follows the widest operand address of the encoding.
    wire logic       fetch_short;
    wire logic       fetch_long;
    wire logic [2:0] fetch_n;

    assign fetch_short = dst_working;
    assign fetch_long  = dst_extended;
    assign fetch_n     = fetch_long  ? FETCH_EXTENDED :
                         fetch_short ? FETCH_WORKING  : FETCH_REGISTER;

    // Extended forms never go through a pointer, so they stay short.
    wire logic       src_indirect;
    wire logic       dst_indirect;
    wire logic       indirect;
    wire logic [2:0] exec_n;

    assign src_indirect = src_indirect_work | src_indirect_reg;
    assign dst_indirect = dst_indirect_reg;
    assign indirect     = (src_indirect | dst_indirect) & !dst_extended;
    assign exec_n       = indirect ? EXEC_INDIRECT : EXEC_DIRECT;

    assign decode.valid        = fam_valid;
    assign decode.with_carry   = with_carry;
    assign decode.extended     = op_adc_ext | op_add_ext;
    assign decode.dst_mode     = dst_m;
    assign decode.src_mode     = src_m;
    assign decode.fetch_cycles = fam_valid ? fetch_n : 3'h0;
    assign decode.exec_cycles  = fam_valid ? exec_n : 3'h0;

    // Plain add masks carry in so a stale carry cannot leak into the sum.
    wire logic       cin;
    wire logic [7:0] sum;
    flags_s          calc;

    assign cin = with_carry & flags_in.c;

    add_flag_unit u_add (
        .a     (dst_value),
        .b     (src_value),
        .cin   (cin),
        .sum   (sum),
        .flags (calc)
    );

    // Per-flag policy of the family: recompute, clear, or keep prior.
    wire flags_s     recompute_mask;
    wire flags_s     clear_mask;
    wire logic [5:0] rec_bits;
    wire logic [5:0] clr_bits;
    wire logic [5:0] calc_bits;
    wire logic [5:0] prior_bits;
    wire logic [5:0] merged_bits;

    assign recompute_mask = '{c: 1'b1, z: 1'b1, s: 1'b1, v: 1'b1,
                              d: 1'b0, h: 1'b1};
    assign clear_mask     = '{c: 1'b0, z: 1'b0, s: 1'b0, v: 1'b0,
                              d: 1'b1, h: 1'b0};
    assign rec_bits   = recompute_mask;
    assign clr_bits   = clear_mask;
    assign calc_bits  = calc;
    assign prior_bits = flags_in;

    for (genvar bit_i = 0; bit_i < 6; bit_i++) begin : g_flag
        assign merged_bits[bit_i] = clr_bits[bit_i] ? 1'b0 :
                                    rec_bits[bit_i] ? calc_bits[bit_i] :
                                    prior_bits[bit_i];
    end

    wire logic       take;
    wire flags_s     next_flags;
    wire logic [7:0] next_result;
    wire logic       next_write_dst;
    wire logic       next_done;

    assign take           = execute & fam_valid;
    // Invalid codes pass the prior flags through unchanged.
    assign next_flags     = take ? flags_s'(merged_bits)
                                 : flags_in;
    assign next_result    = take ? sum : result;
    assign next_write_dst = take;
    // Every execute is answered, so the fetch unit never stalls on a
    // code that belongs to another instruction group.
    assign next_done      = execute;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result <= RESULT_RESET;
        end else begin
            result <= next_result;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_out <= FLAGS_RESET;
        end else begin
            flags_out <= next_flags;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_dst <= 1'b0;
        end else begin
            write_dst <= next_write_dst;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end
endmodule

// ===== dv/cpu_add_carry_decode_chk.sv
// Purpose: Port checks for the add family decoder.
// Assumes: One clock; asynchronous active-low reset.
// Notes: Sums are modelled here, not taken from the decode outputs.
`timescale 1ns/1ps
module cpu_add_carry_decode_chk
    import add_decode_pkg::*;
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] opcode,
    input wire logic       execute,
    input wire logic [7:0] dst_value,
    input wire logic [7:0] src_value,
    input wire flags_s     flags_in,
    input wire decode_s    decode,
    input wire logic [7:0] result,
    input wire flags_s     flags_out,
    input wire logic       write_dst,
    input wire logic       done
);
    wire logic fam = opcode[7:5] == 3'h0 && opcode[3:0] inside {[4'h2:4'h9]};
    wire logic ci = opcode[4] & flags_in.c;
    wire logic [8:0] t = dst_value + src_value + ci;
    wire logic [4:0] hh = dst_value[3:0] + src_value[3:0] + ci;
    wire logic ok = execute && fam;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_adc; ok && opcode[4] |=> result == $past(t[7:0]); endproperty
    a_adc: assert property (p_adc) else $error("adc sum");
    property p_ext; fam && opcode[3] |-> decode.extended
        && decode.dst_mode == extended_register_mode && decode.src_mode ==
        (opcode[0] ? immediate_mode : extended_register_mode); endproperty
    a_ext: assert property (p_ext) else $error("ext mode");
    property p_add; ok && !opcode[4] |=> result == $past(t[7:0])
        && write_dst ##1 write_dst == $past(ok); endproperty
    a_add: assert property (p_add) else $error("add sum");
    property p_vld; decode.valid == fam && decode.with_carry == (fam &&
        opcode[4]) && (fam || decode.fetch_cycles == 3'h0 &&
        decode.exec_cycles == 3'h0 && decode.src_mode == no_mode);
    endproperty
    a_vld: assert property (p_vld) else $error("valid");
    property p_mod; fam && !opcode[3] |-> decode.src_mode == (opcode[2:0] ==
        3'h2 ? working_mode : opcode[2:0] == 3'h3 ? indirect_working_mode :
        opcode[2:0] == 3'h4 ? register_mode : opcode[2:0] == 3'h5 ?
        indirect_register_mode : immediate_mode) && decode.dst_mode ==
        (opcode[2:0] == 3'h7 ? indirect_register_mode : opcode[2:1] == 2'h1
        ? working_mode : register_mode); endproperty
    a_mod: assert property (p_mod) else $error("modes");
    property p_flg; ok |=> !flags_out.d && flags_out.s == result[7]
        && flags_out.z == (result == 8'h00); endproperty
    a_flg: assert property (p_flg) else $error("zsd");
    property p_fch; fam |-> decode.fetch_cycles == (opcode[3] ? FETCH_EXTENDED
        : opcode[3:0] < 4'h4 ? FETCH_WORKING : FETCH_REGISTER); endproperty
    a_fch: assert property (p_fch) else $error("fetch");
    property p_exe; fam |-> decode.exec_cycles ==
        (opcode[0] && !opcode[3] ? EXEC_INDIRECT : EXEC_DIRECT); endproperty
    a_exe: assert property (p_exe) else $error("exec");
    property p_kp; !ok |=> flags_out == $past(flags_in) && !write_dst;
    endproperty
    a_kp: assert property (p_kp) else $error("keep");
    property p_cv; ok |=> flags_out.c == $past(t[8]) && flags_out.h ==
        $past(hh[4]) && flags_out.v == $past(dst_value[7] == src_value[7]
        && t[7] != dst_value[7]); endproperty
    a_cv: assert property (p_cv) else $error("cvh");
endmodule
bind cpu_add_carry_decode cpu_add_carry_decode_chk chk_u (.clk, .arst_n,
    .opcode, .execute, .dst_value, .src_value, .flags_in, .decode, .result,
    .flags_out, .write_dst, .done);

// ===== dv/tb_cpu_add_carry_decode.sv
// Purpose: Self-checking bench for the add family decoder.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Decode timing fields are left to the checker.
`timescale 1ns/1ps
module tb_cpu_add_carry_decode
    import add_decode_pkg::*;
;
`define CHK(g, w) begin check_count++; if ((g) !== (w)) begin n_errors++; \
$display("unexpected at %0t: got %h want %h", $time, g, w); end end
    logic        clk = 1'b0, arst_n = 1'b0, execute = 1'b0;
    logic [7:0]  opcode = 8'h00, dst_value = 8'h00, src_value = 8'h00;
    logic [7:0]  last = 8'h00, result;
    flags_s      flags_in = 6'h00, flags_out;
    decode_s     decode;
    logic        write_dst, done;
    logic [14:0] q[$];
    logic [14:0] note;
    int          n_errors = 0, check_count = 0, cyc = 0;
    always #12.5 clk = ~clk;
    cpu_add_carry_decode dut_u (.clk, .arst_n, .opcode, .execute, .dst_value,
        .src_value, .flags_in, .decode, .result, .flags_out, .write_dst, .done);
    function automatic logic [14:0] model(logic [7:0] o, d, s, flags_s f);
        logic [8:0] t;
        logic [4:0] hh;
        t = d + s + (o[4] & f.c);
        hh = d[3:0] + s[3:0] + (o[4] & f.c);
        if (o[7:5] != 3'h0 || !(o[3:0] inside {[4'h2:4'h9]}))
            return {1'b0, last, f};
        last = t[7:0];
        return {1'b1, t[7:0], t[8], t[7:0] == 8'h00, t[7],
                d[7] == s[7] && t[7] != d[7], 1'b0, hh[4]};
    endfunction
    task automatic op(logic [7:0] o, d, s, flags_s f);
        @(posedge clk);
        #1;
        opcode = o;
        dst_value = d;
        src_value = s;
        flags_in = f;
        execute = 1'b1;
        q.push_back(model(o, d, s, f));
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Every done pulse consumes one note, so a missing pulse shows at the end.
    always @(posedge clk) begin
        #2;
        if (done === 1'b1) begin
            note = q.pop_front();
            `CHK({write_dst, result, flags_out}, note)
        end
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        void'($urandom(33));
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        op(8'h12, 8'hFF, 8'h01, 6'h20);
        op(8'h02, 8'h7F, 8'h01, 6'h3F);
        op(8'h08, 8'h80, 8'h80, 6'h00);
        op(8'h52, 8'h11, 8'h22, 6'h15);
        $display("test edges done");
        for (int i = 0; i < 130; i++)
            op(8'(i % 26), 8'($urandom), 8'($urandom), 6'($urandom));
        @(posedge clk);
        #1 execute = 1'b0;
        repeat (3) @(posedge clk);
        $display("test sweep done");
        `CHK(q.size(), 0)
        results();
    end
endmodule
